//--- shared/jomf_defines.vh
`ifndef JOMF_DEFINES_VH
`define JOMF_DEFINES_VH

// Parameter group numbers and default priority.
`define JOMF_PGN_VDS        18'h0fee8
`define JOMF_PGN_VDS2       18'h0fd89
`define JOMF_PRIO_DEFAULT   3'h6
`define JOMF_DLC            4'h8

// Not-available fill for unmeasured 2-byte and 1-byte fields.
`define JOMF_NA16           16'hffff
`define JOMF_NA8            8'hff

// Angle coding: 1/128 deg per bit, -200 deg offset -> 200*128.
`define JOMF_ANG_OFFSET     16'h6400
// Roll clamp limits in 1/128 deg units (+-90 deg = 11520).
`define JOMF_ROLL_MAX       16'sh2d00
`define JOMF_ROLL_MIN       -16'sh2d00
// Pitch range in 1/128 deg: -200..+301.992 deg -> raw 0..0xfaff.
`define JOMF_PITCH_MIN      -16'sh6400
`define JOMF_PITCH_MAX      17'sh096ff

// Routed signal types.
`define JOMF_SIG_UNDEF      2'h0
`define JOMF_SIG_DISC       2'h1
`define JOMF_SIG_CONT       2'h2

// Router and message sizes.
`define JOMF_NSRC           16
`define JOMF_SEL_W          4
`define JOMF_NSIG           10
`define JOMF_FIFO_DEPTH     4
`define JOMF_FIFO_AW        2

`endif

//--- rtl/jomf_fifo.v
// ****************************************************************
// Frame FIFO
// ****************************************************************
module jomf_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             ref_clk,   // Device clock.
    input  wire             reset_n,   // Async reset, active low.
    input  wire             in_valid,  // Write request.
    output wire             in_ready,  // Space available.
    input  wire [WIDTH-1:0] in_data,   // Write word.
    output wire             out_valid, // Word available.
    input  wire             out_ready, // Read accept.
    output wire [WIDTH-1:0] out_data   // Head word.
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wr_q;
    reg [AW:0]      rd_q;
    wire            full;
    wire            empty;
    wire            push;
    wire            pop;

    // An extra pointer bit tells full from empty without a counter.
    assign full      = (wr_q[AW] != rd_q[AW]) &&
                       (wr_q[AW-1:0] == rd_q[AW-1:0]);
    assign empty     = (wr_q == rd_q);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign push      = in_valid && !full;
    assign pop       = out_ready && !empty;
    assign out_data  = mem[rd_q[AW-1:0]];

    // Storage array has no reset; only pointers carry state.
    always @(posedge ref_clk) begin
        if (push) begin
            mem[wr_q[AW-1:0]] <= in_data;
        end
    end

    // Pointer update.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= {(AW+1){1'b0}};
            rd_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

//--- rtl/jomf_router.v
`include "jomf_defines.vh"
// ****************************************************************
// Signal router
// ****************************************************************
module jomf_router (
    input  wire [16*34-1:0] src_bus,  // 16 sources: type[33:32], value.
    input  wire [10*4-1:0]  sel_bus,  // Source select per input.
    output reg  [10*34-1:0] dst_bus   // 10 routed inputs.
);
    // Any input may pick any output; many inputs may share one.
    integer i;
    always @* begin
        dst_bus = {(10*34){1'b0}};
        for (i = 0; i < `JOMF_NSIG; i = i + 1) begin
            dst_bus[i*34 +: 34] = src_bus[sel_bus[i*4 +: 4]*34 +: 34];
        end
    end
endmodule

//--- rtl/jomf_framer.v
`include "jomf_defines.vh"
// Behaviour
// - Direction/speed group sent only on request.
// - Direction/speed 2 group sent only on request.
// - Bearing, speed, pitch, altitude in two-byte fields.
// - Navigation speed filled with all ones.
// - Altitude filled with all ones.
// - Pitch carries -200 degree offset, bounded range.
// - Roll in first bytes, 1/128 deg, offset.
// - Roll clamped to plus or minus 90.
// - Output message packs up to eight inputs.
// - Input signal output refreshed on reception.
// - Any input routes to any output.
// - Signals are undefined, discrete or continuous.
module jomf_framer (
    input  wire           ref_clk,      // 40 MHz device clock.
    input  wire           reset_n,      // Async reset, active low.
    input  wire signed [15:0] pitch_in, // Pitch, 1/128 deg, signed.
    input  wire signed [15:0] roll_in,  // Roll, 1/128 deg, signed.
    input  wire           req_valid,    // Request pulse from bus side.
    input  wire [17:0]    req_pgn,      // Requested group number.
    output wire           req_ready,    // Request can be taken.
    output wire           tx_valid,     // Frame available.
    input  wire           tx_ready,     // Frame accepted by CAN side.
    output wire [2:0]     tx_prio,      // Frame priority.
    output wire [17:0]    tx_pgn,       // Frame group number.
    output wire [3:0]     tx_dlc,       // Frame length in bytes.
    output wire [63:0]    tx_data,      // Payload, byte 1 in [7:0].
    input  wire           rx_valid,     // Received signal strobe.
    input  wire [3:0]     rx_index,     // Receiving input unit 0..5.
    input  wire [31:0]    rx_value,     // Received value.
    input  wire           rx_cont,      // Value is continuous.
    input  wire [39:0]    route_sel,    // Source pick per message input.
    input  wire [9:0]     sig_enable,   // Packed signals, one per input.
    input  wire           msg_send,     // Pulse: send configured message.
    output reg  [63:0]    msg_data_q,   // Packed configured message.
    output reg  [9:0]     msg_undef_q,  // Enabled inputs undefined at packing.
    output reg  [191:0]   can_sig_q     // Six input units, 32-bit value each.
);
    // ************************************************************
    // Request decode
    // ************************************************************
    localparam ST_IDLE = 3'b001;
    localparam ST_VDS  = 3'b010;
    localparam ST_VDS2 = 3'b100;

    reg  [2:0]  state_q;
    reg  [2:0]  state_d;
    reg  [15:0] pitch_raw_q;
    reg  [15:0] roll_raw_q;
    reg  [81:0] fifo_in;
    wire        fifo_in_ready;
    wire        is_vds;
    wire        is_vds2;
    wire [81:0] fifo_out;

    assign is_vds  = (req_pgn == `JOMF_PGN_VDS);
    assign is_vds2 = (req_pgn == `JOMF_PGN_VDS2);
    // Requests for other groups are simply dropped.
    assign req_ready = (state_q == ST_IDLE);

    // Frames leave only after a matching request, never periodically.
    always @* begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (req_valid && is_vds) begin
                    state_d = ST_VDS;
                end else if (req_valid && is_vds2) begin
                    state_d = ST_VDS2;
                end
            end
            ST_VDS: begin
                if (fifo_in_ready) begin
                    state_d = ST_IDLE;
                end
            end
            ST_VDS2: begin
                if (fifo_in_ready) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Angle encoding
    // ************************************************************
    wire signed [16:0] pitch_ext;
    wire signed [16:0] roll_ext;
    wire [15:0]        pitch_cl;
    wire [15:0]        roll_cl;

    assign pitch_ext = {pitch_in[15], pitch_in};
    assign roll_ext  = {roll_in[15], roll_in};
    // Pitch is saturated into the codable span before the offset.
    assign pitch_cl =
        (pitch_ext < `JOMF_PITCH_MIN) ? `JOMF_PITCH_MIN :
        (pitch_ext > `JOMF_PITCH_MAX) ? 16'h96ff : pitch_in;
    // Roll is held to +-90 deg though coding allows more.
    assign roll_cl =
        (roll_in > `JOMF_ROLL_MAX) ? `JOMF_ROLL_MAX :
        (roll_in < `JOMF_ROLL_MIN) ? `JOMF_ROLL_MIN : roll_in;

    // Sample angles with the request so a frame is self-consistent.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            pitch_raw_q <= 16'h0000;
            roll_raw_q  <= 16'h0000;
        end else if (req_ready && req_valid) begin
            pitch_raw_q <= pitch_cl + `JOMF_ANG_OFFSET;
            roll_raw_q  <= roll_cl + `JOMF_ANG_OFFSET;
        end
    end

    // ************************************************************
    // Payload build
    // ************************************************************
    always @* begin
        fifo_in = {82{1'b0}};
        if (state_q == ST_VDS) begin
            fifo_in[81:79] = `JOMF_PRIO_DEFAULT;
            fifo_in[78:61] = `JOMF_PGN_VDS;
            fifo_in[60:57] = `JOMF_DLC;
            fifo_in[15:0]  = `JOMF_NA16;
            fifo_in[31:16] = `JOMF_NA16;
            fifo_in[47:32] = pitch_raw_q;
            fifo_in[56:48] = 9'h1ff;
        end else begin
            fifo_in[81:79] = `JOMF_PRIO_DEFAULT;
            fifo_in[78:61] = `JOMF_PGN_VDS2;
            fifo_in[60:57] = `JOMF_DLC;
            fifo_in[15:0]  = roll_raw_q;
            fifo_in[56:16] = {41{1'b1}};
        end
    end

    // Bits 63:57 of the payload are constant ones in both groups,
    // so only 57 payload bits are stored; they are restored below.
    jomf_fifo #(
        .WIDTH (82),
        .DEPTH (`JOMF_FIFO_DEPTH),
        .AW    (`JOMF_FIFO_AW)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (state_q != ST_IDLE),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (fifo_out)
    );

    assign tx_prio = fifo_out[81:79];
    assign tx_pgn  = fifo_out[78:61];
    assign tx_dlc  = fifo_out[60:57];
    assign tx_data = {7'h7f, fifo_out[56:0]};

    // ************************************************************
    // Input signal units and routing
    // ************************************************************
    wire [16*34-1:0] src_bus;
    wire [10*34-1:0] dst_bus;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_rx
            // One output per unit, refreshed on its own reception.
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    can_sig_q[g*32 +: 32] <= 32'h00000000;
                end else if (rx_valid && rx_index == g) begin
                    can_sig_q[g*32 +: 32] <= rx_value;
                end
            end
        end
    endgenerate

    // Type of each input unit: undefined until first reception.
    reg [11:0] rx_type_q;
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_rt
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    rx_type_q[g*2 +: 2] <= `JOMF_SIG_UNDEF;
                end else if (rx_valid && rx_index == g) begin
                    rx_type_q[g*2 +: 2] <= rx_cont ? `JOMF_SIG_CONT
                                                   : `JOMF_SIG_DISC;
                end
            end
        end
    endgenerate

    // Sources: 0 undefined, 1 pitch, 2 roll, 3..8 input units, rest
    // undefined.
    assign src_bus[0*34 +: 34] = {`JOMF_SIG_UNDEF, 32'h00000000};
    assign src_bus[1*34 +: 34] = {`JOMF_SIG_DISC, 16'h0000, pitch_raw_q};
    assign src_bus[2*34 +: 34] = {`JOMF_SIG_DISC, 16'h0000, roll_raw_q};
    generate
        for (g = 0; g < 6; g = g + 1) begin : g_src
            assign src_bus[(g+3)*34 +: 34] =
                {rx_type_q[g*2 +: 2], can_sig_q[g*32 +: 32]};
        end
        for (g = 9; g < 16; g = g + 1) begin : g_pad
            assign src_bus[g*34 +: 34] = {`JOMF_SIG_UNDEF, 32'h00000000};
        end
    endgenerate

    jomf_router u_router (
        .src_bus (src_bus),
        .sel_bus (route_sel),
        .dst_bus (dst_bus)
    );

    // ************************************************************
    // Configurable output message
    // ************************************************************
    // Eight of the ten inputs pack one byte each; undefined ones send 0xff.
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_pack
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    msg_data_q[g*8 +: 8] <= `JOMF_NA8;
                end else if (msg_send) begin
                    msg_data_q[g*8 +: 8] <=
                        (!sig_enable[g] ||
                         dst_bus[g*34+32 +: 2] == `JOMF_SIG_UNDEF) ?
                        `JOMF_NA8 : dst_bus[g*34 +: 8];
                end
            end
        end
        for (g = 0; g < 10; g = g + 1) begin : g_undef
            always @(posedge ref_clk or negedge reset_n) begin
                if (!reset_n) begin
                    msg_undef_q[g] <= 1'b1;
                end else if (msg_send) begin
                    msg_undef_q[g] <= sig_enable[g] &&
                        (dst_bus[g*34+32 +: 2] == `JOMF_SIG_UNDEF);
                end
            end
        end
    endgenerate
endmodule

//--- verification/jomf_can_node.sv
// ******************************************************
// Far-side frame consumer
// ******************************************************
module jomf_can_node (
    input  wire logic        ref_clk,          // Clock.
    input  wire logic        reset_n,          // Async reset.
    input  wire logic        tx_valid,         // Frame offered.
    output logic             tx_ready = 1'b0,  // Frame taken.
    input  wire logic [17:0] tx_pgn,           // Offered group.
    input  wire logic [63:0] tx_data,          // Offered payload.
    input  wire logic        stall,            // Hold off acceptance.
    output int               frames,           // Frames taken.
    output logic [17:0]      last_pgn,         // Last group taken.
    output logic [63:0]      last_data         // Last payload taken.
);
    timeunit 1ns;
    timeprecision 1ps;

    // Ready moves just after the rising edge, so it never races the
    // bench, which changes stall on the falling edge.
    always @(posedge ref_clk) tx_ready <= !stall;

    // A frame counts only at an edge where both sides agree.
    always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            frames <= 0;
        end else if (tx_valid && tx_ready) begin
            frames    <= frames + 1;
            last_pgn  <= tx_pgn;
            last_data <= tx_data;
        end
    end
endmodule

//--- verification/jomf_chk.sv
// ******************************************************
// Frame checker
// ******************************************************
module jomf_chk (
    input wire logic        ref_clk,    // Clock.
    input wire logic        reset_n,    // Async reset.
    input wire logic        req_valid,  // Request strobe.
    input wire logic        req_ready,  // Request accepted.
    input wire logic [17:0] req_pgn,    // Requested group.
    input wire logic        tx_valid,   // Frame offered.
    input wire logic        tx_ready,   // Frame taken.
    input wire logic [2:0]  tx_prio,    // Priority.
    input wire logic [17:0] tx_pgn,     // Group.
    input wire logic [3:0]  tx_dlc,     // Length.
    input wire logic [63:0] tx_data     // Payload.
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    // Frame kinds and a known request being taken.
    wire vds  = tx_valid && tx_pgn == 18'h0fee8;
    wire vds2 = tx_valid && tx_pgn == 18'h0fd89;
    wire take = req_valid && req_ready;
    wire good = req_pgn == 18'h0fee8 || req_pgn == 18'h0fd89;

    property p_hdr; tx_valid |-> tx_prio == 3'h6 && tx_dlc == 4'h8;
    endproperty
    a_hdr: assert property (p_hdr) else $error("bad header");
    property p_pgn; tx_valid |-> vds || vds2; endproperty
    a_pgn: assert property (p_pgn) else $error("bad group");
    property p_bear; vds |-> tx_data[15:0] == 16'hffff; endproperty
    a_bear: assert property (p_bear) else $error("bearing");
    property p_speed; vds |-> tx_data[31:16] == 16'hffff; endproperty
    a_speed: assert property (p_speed) else $error("speed");
    property p_alt; vds |-> tx_data[63:48] == 16'hffff; endproperty
    a_alt: assert property (p_alt) else $error("altitude");
    property p_pitch; vds |-> tx_data[47:32] <= 16'hfaff; endproperty
    a_pitch: assert property (p_pitch) else $error("pitch");
    property p_roll;
        vds2 |-> tx_data[15:0] inside {[16'h3700:16'h9100]}
            && tx_data[63:16] == 48'hffffffffffff;
    endproperty
    a_roll: assert property (p_roll) else $error("roll");
    property p_hold;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data)
            && $stable(tx_pgn);
    endproperty
    a_hold: assert property (p_hold) else $error("unstable");
    property p_busy; take && good |=> !req_ready; endproperty
    a_busy: assert property (p_busy) else $error("not busy");
    property p_skip; take && !good |=> req_ready; endproperty
    a_skip: assert property (p_skip) else $error("odd taken");
    property p_cause; $rose(tx_valid) |-> $past(take, 2); endproperty
    a_cause: assert property (p_cause) else $error("unasked");

    c_vds: cover property (vds && tx_ready);
    c_vds2: cover property (vds2 && tx_ready);
    c_full: cover property (tx_valid && !tx_ready ##1 !req_ready);
endmodule

//--- verification/testbench.sv
// ******************************************************
// Bench top
// ******************************************************
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic               ref_clk = 1'b0;
    logic               reset_n = 1'b0;
    logic signed [15:0] pitch_in = '0;
    logic signed [15:0] roll_in = '0;
    logic               req_valid = 1'b0;
    logic [17:0]        req_pgn = '0;
    logic               rx_valid = 1'b0;
    logic [3:0]         rx_index = '0;
    logic [31:0]        rx_value = '0;
    logic               rx_cont = 1'b0;
    logic [39:0]        route_sel = '0;
    logic [9:0]         sig_enable = '0;
    logic               msg_send = 1'b0;
    logic               stall = 1'b0;
    wire                req_ready, tx_valid, tx_ready;
    wire [2:0]          tx_prio;
    wire [17:0]         tx_pgn, last_pgn;
    wire [3:0]          tx_dlc;
    wire [63:0]         tx_data, msg_data_q, last_data;
    wire [9:0]          msg_undef_q;
    wire [191:0]        can_sig_q;
    int                 frames, f0, i;
    int                 error_cnt = 0;
    int                 check_count = 0;

    always #12.5 ref_clk = ~ref_clk;

    jomf_framer dut_u (.ref_clk, .reset_n, .pitch_in, .roll_in,
        .req_valid, .req_pgn, .req_ready, .tx_valid, .tx_ready,
        .tx_prio, .tx_pgn, .tx_dlc, .tx_data, .rx_valid, .rx_index,
        .rx_value, .rx_cont, .route_sel, .sig_enable, .msg_send,
        .msg_data_q, .msg_undef_q, .can_sig_q);
    jomf_can_node node_u (.ref_clk, .reset_n, .tx_valid, .tx_ready,
        .tx_pgn, .tx_data, .stall, .frames, .last_pgn, .last_data);

    task chk(input string nm, input logic [63:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task final_report;
        $display("mismatches %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Wait for an idle framer, then pulse one request.
    task ask(input logic [17:0] pgn);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        chk("idle", 64'(req_ready), 64'h1);
        req_pgn = pgn;
        req_valid = 1'b1;
        @(negedge ref_clk);
        req_valid = 1'b0;
    endtask

    task send(input logic [17:0] pgn, input logic [63:0] exp);
        int n, c;
        c = frames;
        n = 0;
        ask(pgn);
        while (frames == c && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        chk("count", 64'(frames - c), 64'h1);
        chk("group", 64'(last_pgn), 64'(pgn));
        chk("payload", last_data, exp);
    endtask

    task t_reset;
        chk("ready", 64'(req_ready), 64'h1);
        chk("msg", msg_data_q, 64'hffffffffffffffff);
        chk("undef", 64'(msg_undef_q), 64'h3ff);
        chk("units", 64'(|can_sig_q), 64'h0);
    endtask

    // Pitch and roll codings, including both roll clamp limits and the lower pitch limit.
    task t_angles;
        logic signed [15:0] pv [3] = '{16'sh0000, -16'sh7530, 16'sh7fff};
        logic [15:0]        pe [3] = '{16'h6400, 16'h0000, 16'he3ff};
        logic signed [15:0] rv [3] = '{16'sh0500, 16'sh4e20, -16'sh4e20};
        logic [15:0]        re [3] = '{16'h6900, 16'h9100, 16'h3700};
        for (int k = 0; k < 3; k++) begin
            pitch_in = pv[k];
            roll_in = rv[k];
            send(18'h0fee8, {16'hffff, pe[k], 32'hffffffff});
            send(18'h0fd89, {48'hffffffffffff, re[k]});
        end
    endtask

    task t_ignore;
        f0 = frames;
        ask(18'h0feca);
        repeat (6) @(negedge ref_clk);
        chk("unasked", 64'(frames - f0), 64'h0);
    endtask

    // Stall the far side past the FIFO depth, then drain.
    task t_full;
        f0 = frames;
        stall = 1'b1;
        for (i = 0; i < 5; i++) ask(18'h0fee8);
        repeat (4) @(negedge ref_clk);
        chk("held", 64'(req_ready), 64'h0);
        stall = 1'b0;
        for (i = 0; i < 30 && frames != f0 + 5; i++) @(negedge ref_clk);
        chk("drained", 64'(frames - f0), 64'h5);
        chk("empty", 64'(tx_valid), 64'h0);
    endtask

    task t_route;
        rx_index = 4'h2;
        rx_value = 32'h12345678;
        rx_cont = 1'b1;
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        chk("unit", 64'(can_sig_q[95:64]), 64'h12345678);
        route_sel = 40'h0000005605;
        sig_enable = 10'h00f;
        msg_send = 1'b1;
        @(negedge ref_clk);
        msg_send = 1'b0;
        chk("pack", msg_data_q, 64'hffffffff78ffff78);
        chk("types", 64'(msg_undef_q), 64'h006);
        // A discrete reception must also turn its unit defined.
        rx_index = 4'h3;
        rx_value = 32'h000000a5;
        rx_cont = 1'b0;
        rx_valid = 1'b1;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        chk("unit3", 64'(can_sig_q[127:96]), 64'ha5);
        route_sel = {4'h6, {9{4'h5}}};
        sig_enable = 10'h3ff;
        msg_send = 1'b1;
        @(negedge ref_clk);
        msg_send = 1'b0;
        chk("ten", msg_data_q, {8{8'h78}});
        chk("ten_def", 64'(msg_undef_q), 64'h0);
    endtask

    initial begin
        repeat (16) @(negedge ref_clk);
        reset_n = 1'b1;
        @(negedge ref_clk);
        t_reset();
        t_angles();
        t_ignore();
        t_full();
        t_route();
        final_report();
    end

    // Whole run needs under a hundred cycles; this is far beyond it.
    initial begin
        #100us;
        error_cnt++;
        final_report();
    end
endmodule

bind jomf_framer jomf_chk chk_u (.ref_clk, .reset_n, .req_valid,
    .req_ready, .req_pgn, .tx_valid, .tx_ready, .tx_prio, .tx_pgn,
    .tx_dlc, .tx_data);
